// >>> logic/adcof_pkg.sv
// adcof_pkg: constants and carrier types for the converter output formatter.
// assumes one 100 MHz core clock; the pipeline core hands over results on that clock.
package adcof_pkg;

  localparam int          WORD_W         = 10;
  localparam int          LATENCY_TICKS  = 9;
  // period and forwarding delay in picoseconds, as integers
  localparam int          CLK_PERIOD_PS  = 10000;
  localparam int          FWD_DELAY_PS   = 2100;
  // longest time: round down, but never below one cycle
  localparam int          FWD_DELAY_RAW  = FWD_DELAY_PS / CLK_PERIOD_PS;
  localparam int          FWD_DELAY_CYC  = (FWD_DELAY_RAW < 1) ? 1 : FWD_DELAY_RAW;
  localparam int          SYNC_STAGES    = 3;

  localparam logic [9:0]  CODE_ALL_ONES  = 10'h3FF;
  localparam logic [9:0]  CODE_ALL_ZEROS = 10'h000;
  localparam int          MSB_POS        = 9;
  localparam int          LSB_POS        = 0;

  // pin straps after reset: two's complement, half-rate update
  localparam logic        FMT_RESET      = 1'b0;
  localparam logic        RATE_RESET     = 1'b0;
  localparam logic        FMT_TWOS       = 1'b0;

  // one quantised result from the pipeline core, offset binary
  typedef struct packed {
    logic              above_fs;
    logic              below_fs;
    logic [WORD_W-1:0] code;
  } adcof_raw_t;

  // one formatted result on its way to the pins
  typedef struct packed {
    logic              out_of_range;
    logic [WORD_W-1:0] word;
  } adcof_word_t;

endpackage : adcof_pkg

// >>> logic/adcof_formatter.sv
// adcof_formatter: output stage of the pipelined converter: latency line, coding,
// saturation, out-of-range flag, update-rate select and forwarded data clock.
// assumes sample_tick marks each rising sampling-clock edge, at least 4 clk apart,
// and the two strap pins come from outside the clock domain.
//
// What this block does
// - result leaves as a 10-bit word, bit 9 most significant, bit 0 least.
// - every data bit has a true line and a complement line, always inverse.
// - true out-of-range flag goes high for a result beyond the convertible range.
// - complement out-of-range flag goes low then, staying inverse of the true flag.
// - format strap 0 gives two's complement, 1 gives offset binary.
// - format strap defaults low, so an open pin yields two's complement.
// - forwarded data clock rises one 10 ns core cycle after each output update.
// - sample on rising edge; result appears nine sampling cycles later.
// - rate strap 0 updates outputs every second sample, 1 every sample.
// - beyond full scale the word saturates at all ones or all zeros in binary.
`timescale 1ns/10ps

module adcof_formatter
  import adcof_pkg::*;
#(
  parameter int LATENCY = LATENCY_TICKS
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              sample_tick,
  input  wire adcof_raw_t        raw_sample,
  input  wire logic              format_select = 1'b0,
  input  wire logic              half_rate_select = 1'b0,
  output logic [WORD_W-1:0]      data_word_true,
  output logic [WORD_W-1:0]      data_word_comp,
  output logic                   range_flag_true,
  output logic                   range_flag_comp,
  output logic                   fwd_clock_true,
  output logic                   fwd_clock_comp
);

  ////////////////////////////////////////////////////////////////////////////
  // strap synchronisers: three flops, a change counts once stages 2 and 3 agree

  logic [SYNC_STAGES-1:0] fmt_sync_q;
  logic [SYNC_STAGES-1:0] rate_sync_q;
  logic                   fmt_q;
  logic                   full_rate_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fmt_sync_q  <= '0;
      rate_sync_q <= '0;
    end else begin
      fmt_sync_q  <= {fmt_sync_q[SYNC_STAGES-2:0], format_select};
      rate_sync_q <= {rate_sync_q[SYNC_STAGES-2:0], half_rate_select};
    end
  end

  // an unconnected strap falls to the port default of zero
  wire fmt_agree  = fmt_sync_q[1] == fmt_sync_q[2];
  wire rate_agree = rate_sync_q[1] == rate_sync_q[2];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fmt_q       <= FMT_RESET;
      full_rate_q <= RATE_RESET;
    end else begin
      if (fmt_agree) begin
        fmt_q <= fmt_sync_q[2];
      end
      if (rate_agree) begin
        full_rate_q <= rate_sync_q[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // coding and saturation at capture

  wire              in_oor   = raw_sample.above_fs | raw_sample.below_fs;
  // saturate before recoding so both formats share one clamp
  wire [WORD_W-1:0] sat_code = raw_sample.above_fs ? CODE_ALL_ONES :
                               raw_sample.below_fs ? CODE_ALL_ZEROS :
                               raw_sample.code;
  // two's complement is offset binary with the top bit flipped
  wire [WORD_W-1:0] fmt_code = (fmt_q == FMT_TWOS) ?
                               {~sat_code[MSB_POS], sat_code[MSB_POS-1:LSB_POS]} :
                               sat_code;
  wire adcof_word_t cap_word = '{out_of_range: in_oor, word: fmt_code};

  ////////////////////////////////////////////////////////////////////////////
  // latency line: LATENCY stages, then the output register loads at the LATENCY-th
  // tick after capture, so a sample shows LATENCY sampling cycles after its edge

  adcof_word_t pipe_q [LATENCY];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pipe_q[0] <= '0;
    end else if (sample_tick) begin
      pipe_q[0] <= cap_word;
    end
  end

  genvar gi;
  generate
    for (gi = 1; gi < LATENCY; gi++) begin : g_stage
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pipe_q[gi] <= '0;
        end else if (sample_tick) begin
          pipe_q[gi] <= pipe_q[gi-1];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // update rate: every tick at full rate, every other tick at half rate

  logic        phase_q;
  adcof_word_t head;
  logic        upd;

  assign head = pipe_q[LATENCY-1];
  assign upd  = sample_tick & (full_rate_q | phase_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 1'b0;
    end else if (sample_tick) begin
      phase_q <= ~phase_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output pins; word and flag share one enable so they never split

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_word_true  <= '0;
      data_word_comp  <= '1;
      range_flag_true <= 1'b0;
      range_flag_comp <= 1'b1;
    end else if (upd) begin
      data_word_true  <= head.word;
      data_word_comp  <= ~head.word;
      range_flag_true <= head.out_of_range;
      range_flag_comp <= ~head.out_of_range;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // forwarded clock: rises FWD_DELAY_CYC after the data settle, falls at next tick;
  // the sub-cycle delay cannot be resolved, so it rounds up to one full cycle

  logic [FWD_DELAY_CYC:0] upd_sr_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upd_sr_q       <= '0;
      fwd_clock_true <= 1'b0;
      fwd_clock_comp <= 1'b1;
    end else begin
      upd_sr_q <= {upd_sr_q[FWD_DELAY_CYC-1:0], upd};
      if (upd_sr_q[FWD_DELAY_CYC-1]) begin
        fwd_clock_true <= 1'b1;
        fwd_clock_comp <= 1'b0;
      end else if (sample_tick) begin
        fwd_clock_true <= 1'b0;
        fwd_clock_comp <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [3:0] tick_cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
    end else if (sample_tick && tick_cnt_q != 4'hF) begin
      tick_cnt_q <= tick_cnt_q + 4'h1;
    end
  end

  // rate history for the update-rate check; the first half-rate tick must skip
  logic last_upd_q;
  logic last_full_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_upd_q  <= 1'b1;
      last_full_q <= RATE_RESET;
    end else if (sample_tick) begin
      last_upd_q  <= upd;
      last_full_q <= full_rate_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_update;
    upd;
  endsequence

  sequence s_fwd_edge;
    !fwd_clock_true ##1 fwd_clock_true;
  endsequence

  a_comp_inverse: assert property (data_word_comp == ~data_word_true)
    else $error("data complement not inverse of true word");
  a_flag_inverse: assert property (range_flag_comp == ~range_flag_true)
    else $error("range complement not inverse of true flag");
  a_sat_pos_clamp: assert property (s_update and head.out_of_range
      && head.word == {fmt_q, {(WORD_W-1){1'b1}}} |=> range_flag_true
      && data_word_true[MSB_POS-1:LSB_POS] == {(WORD_W-1){1'b1}})
    else $error("positive clamp word or flag wrong");
  a_fmt_binary: assert property (sample_tick && !in_oor && fmt_q
      |=> pipe_q[0].word == $past(raw_sample.code))
    else $error("offset binary word wrong");
  a_fmt_twos: assert property (sample_tick && raw_sample.above_fs && !fmt_q
      |=> pipe_q[0].out_of_range && pipe_q[0].word == 10'h1FF)
    else $error("two's complement clamp or flag wrong");
  a_flag_aligned: assert property ($changed(range_flag_true)
      |-> $past(upd) && data_word_true == $past(head.word))
    else $error("flag changed without its word");
  a_fwd_follows: assert property (s_update |=> s_fwd_edge)
    else $error("forwarded clock did not rise after data");
  a_rate_select: assert property (sample_tick
      |-> (full_rate_q ? upd : (last_full_q || upd != last_upd_q)))
    else $error("update rate wrong");
  a_no_early: assert property (tick_cnt_q < 4'(LATENCY) |-> data_word_true == '0
      && !range_flag_true)
    else $error("result before latency elapsed");

endmodule : adcof_formatter

// >>> sim/adcof_rx_model.sv
// adcof_rx_model: downstream receiver that latches each output word and flag.
// assumes the word and flag are settled at every rising edge of the forwarded clock.
`timescale 1ns/10ps

module adcof_rx_model
  import adcof_pkg::*;
(
  input  wire logic              fwd_clock_true,
  input  wire logic [WORD_W-1:0] data_word_true,
  input  wire logic              range_flag_true,
  output logic      [WORD_W-1:0] cap_word,
  output logic                   cap_flag
);
  // timed by the forwarded clock only; the core clock is not visible here
  always_ff @(posedge fwd_clock_true) begin
    cap_word <= data_word_true;
    cap_flag <= range_flag_true;
  end
endmodule : adcof_rx_model

// >>> sim/adcof_formatter_tb.sv
// adcof_formatter_tb: random samples through all four strap settings, compared
// against a queue model of the latency line, coding and update rate.
// assumes ticks five clk apart and straps settled before each reset release.
`timescale 1ns/10ps

module adcof_formatter_tb;
  import adcof_pkg::*;
  logic              clk, rst_n, sample_tick, format_select, half_rate_select;
  adcof_raw_t        raw_sample, r;
  logic [WORD_W-1:0] data_word_true, data_word_comp, cap_word, bin;
  logic              range_flag_true, range_flag_comp, fwd_clock_true, fwd_clock_comp, cap_flag;
  logic [10:0]       fmtd;
  logic [10:0]       hist[$];
  int                num_errors, num_checks, n, sel;
  bit                have_exp, upd;

  adcof_formatter adcof_formatter_i (
    .clk(clk), .rst_n(rst_n), .sample_tick(sample_tick), .raw_sample(raw_sample),
    .format_select(format_select), .half_rate_select(half_rate_select),
    .data_word_true(data_word_true), .data_word_comp(data_word_comp),
    .range_flag_true(range_flag_true), .range_flag_comp(range_flag_comp),
    .fwd_clock_true(fwd_clock_true), .fwd_clock_comp(fwd_clock_comp));

  adcof_rx_model adcof_rx_model_i (
    .fwd_clock_true(fwd_clock_true), .data_word_true(data_word_true),
    .range_flag_true(range_flag_true), .cap_word(cap_word), .cap_flag(cap_flag));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n            = 1'b0;
    sample_tick      = 1'b0;
    raw_sample       = '0;
    format_select    = 1'b0;
    half_rate_select = 1'b0;
    num_errors       = 0;
    num_checks       = 0;
    n = $urandom(32'h1555);
    // p[0] picks the coding, p[1] the update rate
    for (int p = 0; p < 4; p++) begin
      @(posedge clk);
      rst_n            <= 1'b0;
      format_select    <= p[0];
      half_rate_select <= p[1];
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      hist.delete();
      have_exp = 1'b0;
      for (n = 1; n <= 40; n++) begin
        r.code     = WORD_W'($urandom);
        sel        = $urandom % 8;
        r.above_fs = (sel == 0) || (sel == 2);
        r.below_fs = (sel == 1) || (sel == 2);
        // saturate in binary first; above full scale wins when both are set
        bin = r.above_fs ? CODE_ALL_ONES : (r.below_fs ? CODE_ALL_ZEROS : r.code);
        hist.push_back({r.above_fs | r.below_fs, p[0] ? bin : (bin ^ 10'h200)});
        @(posedge clk);
        raw_sample  <= r;
        sample_tick <= 1'b1;
        @(posedge clk);
        sample_tick <= 1'b0;
        raw_sample  <= ~r;
        // tick n shows the sample of tick n-9; at half rate only even ticks update
        upd = (n >= 10) && (p[1] || (n % 2 == 0));
        if (upd) begin
          fmtd     = hist[n-10];
          have_exp = 1'b1;
        end
        repeat (3) @(posedge clk);
        #1;
        if (have_exp) begin
          check("word", data_word_true, fmtd[9:0]);
          check("word_comp", data_word_comp, {1'b0, ~fmtd[9:0]});
          check("flag", range_flag_true, fmtd[10]);
          check("flag_comp", range_flag_comp, {10'h000, ~fmtd[10]});
          check("capture", {cap_flag, cap_word}, fmtd);
        end
        if (upd)
          check("fwd_clock", {fwd_clock_true, fwd_clock_comp}, 2'b10);
      end
    end
    stop_test;
  end
endmodule : adcof_formatter_tb
